// ### verilog/sdi_pkg.sv
// Purpose: shared constants and types of the step/direction input sequencer
// Assumes: 250 MHz core clock
// Notes: times are held in their printed unit, cycle counts derive from them
package sdi_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CANCEL_NS = 2000;
  // longest time: rounds down
  localparam int unsigned CANCEL_CYC = (CANCEL_NS * CLK_MHZ) / 1000;
  localparam int unsigned IDLE_MS = 1500;
  localparam int unsigned IDLE_CYC_DEF = IDLE_MS * CLK_MHZ * 1000;
  localparam int unsigned POS_W = 8;
  localparam int unsigned TMR_W = 32;
  localparam logic [POS_W-1:0] POS_RST = 8'h00;
  localparam logic [2:0] SYNC_RST = 3'h7;
  localparam logic [1:0] LVL_FULL = 2'h2;
  localparam logic [1:0] LVL_REDUCED = 2'h1;
  localparam logic [1:0] LVL_OFF = 2'h0;

  typedef struct packed {
    logic step_n;
    logic dir_n;
    logic disable_lvl;
    logic reduce_n;
  } sdi_pins_t;

  typedef struct packed {
    logic [POS_W-1:0] position;
    logic [1:0] current_level;
  } sdi_drive_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_FULL = 3'b010,
    ST_REDUCED = 3'b100
  } sdi_state_t;
endpackage

// ### verilog/sdi_sync.sv
// Purpose: three-stage pin synchroniser with agreement of last two stages
// Assumes: input is asynchronous to clock
// Notes: first stage is read only by the second
module sdi_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic fall
);
  import sdi_pkg::*;
  logic [2:0] sh_q;
  logic level_q;
  wire agree = (sh_q[1] == sh_q[2]);
  wire level_d = agree ? sh_q[2] : level_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sh_q <= SYNC_RST;
      level_q <= 1'b1;
    end else begin
      sh_q <= {sh_q[1:0], pin};
      level_q <= level_d;
    end
  end
  assign level = level_q;
  // open inputs idle high, so only a high-to-low change is a fall
  assign fall = level_q & ~level_d;
endmodule

// ### verilog/sdi_sequencer.sv
// Purpose: step/direction input sequencing of a microstep driver
// Assumes: pins idle high when open; one 250 MHz clock
// Notes: position output wraps; the phase table lies downstream
// Behaviour
// - each falling step edge moves position once
// - direction high counts forward, low backward
// - disable high switches phase current off
// - disable low restores phase current
// - position keeps counting while disabled
// - re-enable drives the newly reached position
// - reduction request is active low
// - idle with request lowers current after timeout
// - request withdrawn restores full current at once
// - step edge cancels reduction within 2us
module sdi_sequencer #(
  parameter int unsigned IDLE_CYC = sdi_pkg::IDLE_CYC_DEF
) (
  input wire logic clock,
  input wire logic rst,
  input wire sdi_pkg::sdi_pins_t pins,
  output sdi_pkg::sdi_drive_t drive,
  output logic step_pulse
);
  import sdi_pkg::*;

  logic step_lvl, step_fall, dir_lvl, dis_lvl, red_lvl;

  // each pin passes its own three-stage sampler
  sdi_sync u_step (
    .clock(clock),
    .rst(rst),
    .pin(pins.step_n),
    .level(step_lvl),
    .fall(step_fall)
  );
  sdi_sync u_dir (
    .clock(clock),
    .rst(rst),
    .pin(pins.dir_n),
    .level(dir_lvl),
    .fall()
  );
  sdi_sync u_dis (
    .clock(clock),
    .rst(rst),
    .pin(pins.disable_lvl),
    .level(dis_lvl),
    .fall()
  );
  sdi_sync u_red (
    .clock(clock),
    .rst(rst),
    .pin(pins.reduce_n),
    .level(red_lvl),
    .fall()
  );

  function automatic logic [POS_W-1:0] next_pos(input logic [POS_W-1:0] p,
                                                input logic fwd);
    next_pos = fwd ? POS_W'(p + 1'b1) : POS_W'(p - 1'b1);
  endfunction

  logic [POS_W-1:0] pos_q, pos_d;
  logic [TMR_W-1:0] idle_q, idle_d;
  logic step_pulse_q;
  sdi_state_t st_q, st_d;
  logic [1:0] lvl_q, lvl_d;

  // counting does not look at disable, so steps keep landing while off
  assign pos_d = step_fall ? next_pos(pos_q, dir_lvl) : pos_q;
  wire idle_done = (idle_q >= TMR_W'(IDLE_CYC));
  assign idle_d = step_fall ? '0 :
                  (idle_done ? idle_q : TMR_W'(idle_q + 1'b1));
  wire reduce_req = ~red_lvl;

  // disable outranks reduction; a step in the timeout cycle keeps full
  wire go_off = dis_lvl;
  wire go_red = reduce_req && idle_done && !step_fall;
  wire go_full = !reduce_req || step_fall;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_OFF: begin
        if (!go_off) st_d = ST_FULL;
      end
      ST_FULL: begin
        if (go_off) st_d = ST_OFF;
        else if (go_red) st_d = ST_REDUCED;
      end
      ST_REDUCED: begin
        if (go_off) st_d = ST_OFF;
        else if (go_full) st_d = ST_FULL;
      end
      default: st_d = ST_OFF;
    endcase
  end

  assign lvl_d = (st_d == ST_FULL) ? LVL_FULL :
                 (st_d == ST_REDUCED) ? LVL_REDUCED : LVL_OFF;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pos_q <= POS_RST;
      idle_q <= '0;
      st_q <= ST_OFF;
      lvl_q <= LVL_OFF;
      step_pulse_q <= 1'b0;
    end else begin
      pos_q <= pos_d;
      idle_q <= idle_d;
      st_q <= st_d;
      lvl_q <= lvl_d;
      step_pulse_q <= step_fall;
    end
  end

  // output always carries the live position, so re-enable uses it directly
  assign drive = '{position: pos_q, current_level: lvl_q};
  assign step_pulse = step_pulse_q;

  // assertions
  localparam int CANCEL_WIN = CANCEL_CYC;

  a_step_moves: assert property (
    @(posedge clock) disable iff (rst)
    step_pulse |-> drive.position != $past(drive.position))
    else $error("step did not move position");
  a_one_pulse: assert property (
    @(posedge clock) disable iff (rst)
    step_pulse |=> !step_pulse)
    else $error("step pulse longer than one cycle");
  a_pulse_follows: assert property (
    @(posedge clock) disable iff (rst)
    step_fall |=> step_pulse)
    else $error("counted step gave no pulse");
  a_pos_hold: assert property (
    @(posedge clock) disable iff (rst)
    !step_fall |=> drive.position == $past(drive.position))
    else $error("position moved without a step");
  a_dir_sign: assert property (
    @(posedge clock) disable iff (rst)
    step_fall && dir_lvl |=> pos_q == POS_W'($past(pos_q) + 1'b1))
    else $error("forward step wrong");
  a_dir_back: assert property (
    @(posedge clock) disable iff (rst)
    step_fall && !dir_lvl |=> pos_q == POS_W'($past(pos_q) - 1'b1))
    else $error("backward step wrong");

  a_off_when_dis: assert property (
    @(posedge clock) disable iff (rst)
    dis_lvl |=> drive.current_level == LVL_OFF)
    else $error("current not off while disabled");
  a_off_needs_dis: assert property (
    @(posedge clock) disable iff (rst)
    drive.current_level == LVL_OFF |-> $past(dis_lvl))
    else $error("current off while enabled");
  a_on_when_en: assert property (
    @(posedge clock) disable iff (rst)
    !dis_lvl && !reduce_req |=> drive.current_level == LVL_FULL)
    else $error("current not restored");
  a_count_dis: assert property (
    @(posedge clock) disable iff (rst)
    dis_lvl && step_fall |=> pos_q != $past(pos_q))
    else $error("no count while disabled");
  a_dis_pulse: assert property (
    @(posedge clock) disable iff (rst)
    dis_lvl && step_fall |=> step_pulse)
    else $error("no step pulse while disabled");

  a_no_early_red: assert property (
    @(posedge clock) disable iff (rst)
    drive.current_level == LVL_REDUCED |-> reduce_req || $past(reduce_req))
    else $error("reduced without request");
  a_red_after_idle: assert property (
    @(posedge clock) disable iff (rst)
    drive.current_level == LVL_REDUCED |-> $past(idle_done))
    else $error("reduced before standstill timeout");
  a_red_not_dis: assert property (
    @(posedge clock) disable iff (rst)
    drive.current_level == LVL_REDUCED |-> !$past(dis_lvl))
    else $error("reduced current while disabled");
  a_red_timeout: assert property (
    @(posedge clock) disable iff (rst)
    reduce_req && !dis_lvl && idle_done && !step_fall
      ##1 reduce_req && !dis_lvl && !step_fall
      |=> drive.current_level == LVL_REDUCED)
    else $error("reduction late");
  a_red_release: assert property (
    @(posedge clock) disable iff (rst)
    !reduce_req |=> drive.current_level != LVL_REDUCED)
    else $error("reduction kept after request withdrawn");
  a_red_cancel: assert property (
    @(posedge clock) disable iff (rst)
    step_fall && !dis_lvl |=> drive.current_level == LVL_FULL)
    else $error("step did not cancel reduction");
  // measured from the pin, so the sampler delay counts against the window
  a_cancel_in_time: assert property (
    @(posedge clock) disable iff (rst)
    $fell(pins.step_n) |-> ##[1:CANCEL_WIN] drive.current_level != LVL_REDUCED)
    else $error("reduction not cancelled in time");
  a_idle_restart: assert property (
    @(posedge clock) disable iff (rst)
    step_fall |=> idle_q == '0)
    else $error("idle timer not restarted by step");
  a_idle_climbs: assert property (
    @(posedge clock) disable iff (rst)
    !step_fall && !idle_done |=> idle_q == TMR_W'($past(idle_q) + 1'b1))
    else $error("idle timer did not advance");

  // scenarios the bench should reach
  c_reduced: cover property (@(posedge clock) disable iff (rst)
    st_q == ST_REDUCED ##1 st_q == ST_FULL);
  c_dis_step: cover property (@(posedge clock) disable iff (rst)
    dis_lvl && step_fall);
  c_reenable: cover property (@(posedge clock) disable iff (rst)
    st_q == ST_OFF ##1 st_q == ST_FULL);
  c_cancel: cover property (@(posedge clock) disable iff (rst)
    st_q == ST_REDUCED && step_fall);
  c_withdraw: cover property (@(posedge clock) disable iff (rst)
    st_q == ST_REDUCED && !reduce_req);
endmodule

// ### bench/sdi_ctl_model.sv
// Purpose: motion controller model driving the sequencer pins
// Assumes: 4 ns clock; pins change 1 ns after a rising edge
// Notes: timings sit just above their minimum to stress the sampler
module sdi_ctl_model (
  input wire logic clock,
  output sdi_pkg::sdi_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import sdi_pkg::*;
  initial pins = 4'hF;
  task automatic edge1();
    @(posedge clock);
    #1;
  endtask
  task automatic put(input logic dis, input logic red_n);
    edge1();
    pins.disable_lvl = dis;
    pins.reduce_n = red_n;
  endtask
  task automatic step();
    edge1();
    pins.step_n = 1'b0;
    #2100;
    edge1();
    pins.step_n = 1'b1;
    #2100;
  endtask
  task automatic set_dir(input logic fwd);
    edge1();
    pins.dir_n = fwd;
    #120500;
  endtask
endmodule

// ### bench/test_sdi_sequencer.sv
// Purpose: self-checking bench of the step/direction sequencer
// Assumes: controller model keeps the pin timing
// Notes: idle timeout shortened, yet longer than the 2 us cancel window
module test_sdi_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import sdi_pkg::*;
  // 2.4 us: full current must still stand when the cancel check looks
  localparam int unsigned IDLE = 600;
  logic clock = 1'b0;
  logic rst = 1'b1;
  sdi_pins_t pins;
  sdi_drive_t drive;
  logic step_pulse;
  int fail_count = 0;
  int checks = 0;
  int pulses = 0;
  sdi_ctl_model m (.clock(clock), .pins(pins));
  sdi_sequencer #(.IDLE_CYC(IDLE)) dut (.clock(clock), .rst(rst),
    .pins(pins), .drive(drive), .step_pulse(step_pulse));
  initial forever #2 clock = ~clock;
  always @(posedge clock) if (step_pulse === 1'b1) pulses++;
  task automatic cmp(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // look at outputs away from the edge that launches them
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic t_forward();
    m.put(1'b0, 1'b1);
    settle(8);
    cmp("level on", {6'h00, LVL_FULL}, drive.current_level);
    repeat (3) m.step();
    cmp("fwd pos", 8'h03, drive.position);
    cmp("pulses", 8'h03, pulses[7:0]);
    $display("forward done");
  endtask
  task automatic t_disable();
    m.set_dir(1'b0);
    m.put(1'b1, 1'b1);
    settle(8);
    cmp("level off", {6'h00, LVL_OFF}, drive.current_level);
    repeat (4) m.step();
    cmp("dis pos", 8'hFF, drive.position);
    cmp("dis pulses", 8'h07, pulses[7:0]);
    m.put(1'b0, 1'b1);
    settle(8);
    cmp("reenable", {6'h00, LVL_FULL}, drive.current_level);
    cmp("reenable pos", 8'hFF, drive.position);
    $display("disable done");
  endtask
  task automatic t_reduce();
    m.put(1'b0, 1'b0);
    settle(IDLE + 8);
    cmp("reduced", {6'h00, LVL_REDUCED}, drive.current_level);
    fork
      m.step();
      begin
        #1990;
        cmp("cancel", {6'h00, LVL_FULL}, drive.current_level);
      end
    join
    cmp("re-idle", {6'h00, LVL_REDUCED}, drive.current_level);
    cmp("red pos", 8'hFE, drive.position);
    m.put(1'b0, 1'b1);
    settle(6);
    cmp("restore", {6'h00, LVL_FULL}, drive.current_level);
    $display("reduce done");
  endtask
  initial begin
    #15 rst = 1'b0;
    t_forward();
    t_disable();
    t_reduce();
    close_out();
  end
  initial begin
    // the tests need about 160 us; this leaves ample slack
    #250000;
    fail_count++;
    close_out();
  end
endmodule
